// file: shared/pdmmi_pkg.sv
// Constants of the digital microphone input block: register indices,
// field positions, reset values and mode codes.
// Assumes a 32-bit APB register bus with byte address = 4 * index.
package pdmmi_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_MODE = 8'h6b;    // Oversampling select, index 107
  localparam logic [7:0] IDX_EDGE = 8'h19;    // Latching edge select, index 25
  localparam logic [7:0] IDX_CLKDIV = 8'h40;  // Mic clock half period
  localparam logic [7:0] IDX_STATUS = 8'h41;  // Block state

  // Field positions
  localparam int unsigned FLD_LO = 4;         // Both config fields sit at D5-D4
  localparam int unsigned ST_EN_BIT = 0;
  localparam int unsigned ST_OVF_BIT = 1;
  localparam int unsigned ST_CNT_LO = 4;

  // Oversampling select codes; zero switches the mic mode off
  localparam logic [1:0] OSR_OFF = 2'h0;
  localparam logic [1:0] OSR_128 = 2'h1;
  localparam logic [1:0] OSR_64 = 2'h2;
  localparam logic [1:0] OSR_32 = 2'h3;

  // Latching edge codes
  localparam logic [1:0] EDGE_BOTH = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;

  // Values after reset
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [1:0] EDGE_RST = 2'h0;
  localparam logic [7:0] CLKDIV_RST = 8'h0c;  // 12 core cycles per half period

  // Stream shape
  localparam int unsigned SMP_W = 8;          // Ones count per channel, up to 128
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned SYNC_LAT = 2;       // Cycles through the pin synchroniser

endpackage

// file: design/pdmmi_sync.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to the clock.
`timescale 1ns/1ps
`default_nettype none
module pdmmi_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Level in and out
  input wire logic i_d,
  output logic o_q
);
  logic meta_ff;
  logic q_ff;

  // First stage is read only by the second
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_ff <= 1'b0;
      q_ff <= 1'b0;
    end else begin
      meta_ff <= i_d;
      q_ff <= meta_ff;
    end
  end

  assign o_q = q_ff;
endmodule // pdmmi_sync
`default_nettype wire

// file: design/pdmmi_fifo.sv
// Flop-based FIFO with valid/ready on both sides and an occupancy count.
// Assumes a single clock; push and pop may happen in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module pdmmi_fifo #(
  parameter int unsigned W = 16,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data,
  // Occupancy
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic push, pop;

  // Room while fewer than DEPTH words are held; an empty queue must accept
  assign o_in_ready = (32'(cnt_ff) < DEPTH);
  assign o_out_valid = (cnt_ff != '0);
  assign o_out_data = mem_ff[rd_ff];
  assign o_count = cnt_ff;
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // Pointer and count update; wrap is explicit since depth need not be 2**AW
  always_comb begin
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_wr = (32'(wr_ff) == DEPTH - 1) ? '0 : wr_ff + 1'b1;
    end
    if (pop) begin
      nxt_rd = (32'(rd_ff) == DEPTH - 1) ? '0 : rd_ff + 1'b1;
    end
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage holds no reset; only written words are ever read
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= i_in_data;
    end
  end
endmodule // pdmmi_fifo
`default_nettype wire

// file: design/pdmmi_top.sv
// Digital microphone input: drives the oversampling clock, latches the
// shared data pin on rising (left) and falling (right) edges, decimates
// each bitstream and queues stereo samples for the audio serial path.
// Assumes an APB master on the core clock and a sample consumer with
// valid/ready on the same clock; the data pin is asynchronous.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pdmmi_top
  import pdmmi_pkg::*;
(
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Microphone pins
  output logic O_MIC_CLK,
  output logic O_MIC_CLK_OE_B,
  input wire logic I_MIC_DATA,
  // Decimated samples toward the audio serial path
  output logic O_PCM_VALID,
  input wire logic I_PCM_READY,
  output logic [pdmmi_pkg::SMP_W-1:0] O_PCM_LEFT,
  output logic [pdmmi_pkg::SMP_W-1:0] O_PCM_RIGHT,
  // Converter input select: high while mics replace the analog inputs
  output logic O_ADC_SRC_MIC
);
  import pdmmi_pkg::*;

  // Register hit on an aligned word at byte address 4 * index
  function automatic logic reg_hit(input logic [11:0] addr, input logic [7:0] idx);
    reg_hit = (addr == {2'h0, idx, 2'h0});
  endfunction

  // Bits per frame minus one for an oversampling code
  function automatic logic [7:0] osr_last(input logic [1:0] sel);
    case (sel)
      OSR_128: osr_last = 8'h7f;
      OSR_64: osr_last = 8'h3f;
      default: osr_last = 8'h1f;
    endcase
  endfunction

  // Register state
  logic [1:0] osr_sel_ff, nxt_osr_sel;
  logic [1:0] edge_sel_ff, nxt_edge_sel;
  logic [7:0] clkdiv_ff, nxt_clkdiv;
  logic ovf_ff, nxt_ovf;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic mic_en, wr_acc, mapped;
  logic [$clog2(FIFO_DEPTH):0] fifo_cnt;

  assign mic_en = (osr_sel_ff != OSR_OFF);
  // A write lands only at the edge where pready is seen high
  assign wr_acc = I_PSEL && I_PENABLE && pready_ff && I_PWRITE;
  assign mapped = reg_hit(I_PADDR, IDX_MODE) || reg_hit(I_PADDR, IDX_EDGE) ||
                  reg_hit(I_PADDR, IDX_CLKDIV) || reg_hit(I_PADDR, IDX_STATUS);

  // Sample path state
  logic ovf_set;

  // APB decode: one wait state so read data comes from a flop
  always_comb begin
    nxt_osr_sel = osr_sel_ff;
    nxt_edge_sel = edge_sel_ff;
    nxt_clkdiv = clkdiv_ff;
    nxt_ovf = ovf_ff;
    nxt_pready = I_PSEL && I_PENABLE && !pready_ff;
    nxt_pslverr = I_PSEL && I_PENABLE && !pready_ff && !mapped;
    nxt_prdata = '0;
    if (wr_acc && reg_hit(I_PADDR, IDX_MODE)) begin
      nxt_osr_sel = I_PWDATA[FLD_LO +: 2];
    end
    if (wr_acc && reg_hit(I_PADDR, IDX_EDGE)) begin
      nxt_edge_sel = I_PWDATA[FLD_LO +: 2];
    end
    if (wr_acc && reg_hit(I_PADDR, IDX_CLKDIV) && I_PWDATA[7:0] != 8'h00) begin
      nxt_clkdiv = I_PWDATA[7:0]; // Zero would wrap the compare to 255, a 256-cycle half period
    end
    // Write one clears overflow, but a new overflow in that cycle wins
    if (wr_acc && reg_hit(I_PADDR, IDX_STATUS) && I_PWDATA[ST_OVF_BIT]) begin
      nxt_ovf = 1'b0;
    end
    if (ovf_set) begin
      nxt_ovf = 1'b1;
    end
    if (I_PSEL && I_PENABLE && !pready_ff && !I_PWRITE) begin
      if (reg_hit(I_PADDR, IDX_MODE)) begin
        nxt_prdata[FLD_LO +: 2] = osr_sel_ff;
      end else if (reg_hit(I_PADDR, IDX_EDGE)) begin
        nxt_prdata[FLD_LO +: 2] = edge_sel_ff;
      end else if (reg_hit(I_PADDR, IDX_CLKDIV)) begin
        nxt_prdata[7:0] = clkdiv_ff;
      end else if (reg_hit(I_PADDR, IDX_STATUS)) begin
        nxt_prdata[ST_EN_BIT] = mic_en;
        nxt_prdata[ST_OVF_BIT] = ovf_ff;
        nxt_prdata[ST_CNT_LO +: $clog2(FIFO_DEPTH) + 1] = fifo_cnt;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      osr_sel_ff <= MODE_RST;
      edge_sel_ff <= EDGE_RST;
      clkdiv_ff <= CLKDIV_RST;
      ovf_ff <= 1'b0;
      prdata_ff <= '0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      osr_sel_ff <= nxt_osr_sel;
      edge_sel_ff <= nxt_edge_sel;
      clkdiv_ff <= nxt_clkdiv;
      ovf_ff <= nxt_ovf;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Clock divider state
  logic [7:0] div_cnt_ff, nxt_div_cnt;
  logic mclk_ff, nxt_mclk;
  logic oe_b_ff, nxt_oe_b;
  logic [SYNC_LAT-1:0] rise_dly_ff, nxt_rise_dly;
  logic [SYNC_LAT-1:0] fall_dly_ff, nxt_fall_dly;
  logic toggle;

  assign toggle = mic_en && (div_cnt_ff == clkdiv_ff - 8'h01);

  // Oversampling clock; edge marks are delayed to line up with the
  // synchronised data, which lags the pin by the same two cycles
  always_comb begin
    nxt_div_cnt = toggle ? 8'h00 : div_cnt_ff + 8'h01;
    nxt_mclk = toggle ? !mclk_ff : mclk_ff;
    nxt_oe_b = !mic_en;
    nxt_rise_dly = {rise_dly_ff[SYNC_LAT-2:0], toggle && !mclk_ff};
    nxt_fall_dly = {fall_dly_ff[SYNC_LAT-2:0], toggle && mclk_ff};
    if (!mic_en) begin
      nxt_div_cnt = 8'h00;
      nxt_mclk = 1'b0;
      nxt_rise_dly = '0;
      nxt_fall_dly = '0;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      div_cnt_ff <= 8'h00;
      mclk_ff <= 1'b0;
      oe_b_ff <= 1'b1;
      rise_dly_ff <= '0;
      fall_dly_ff <= '0;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
      mclk_ff <= nxt_mclk;
      oe_b_ff <= nxt_oe_b;
      rise_dly_ff <= nxt_rise_dly;
      fall_dly_ff <= nxt_fall_dly;
    end
  end

  // Data pin synchroniser
  logic mic_data_s;

  pdmmi_sync u_data_sync (
    .i_clk(I_CORE_CLK),
    .i_rst_b(I_RST_B),
    .i_d(I_MIC_DATA),
    .o_q(mic_data_s)
  );

  // Decimation state: a boxcar of ones per frame of osr clock periods
  logic [SMP_W-1:0] acc_l_ff, nxt_acc_l;
  logic [SMP_W-1:0] acc_r_ff, nxt_acc_r;
  logic [7:0] bit_cnt_ff, nxt_bit_cnt;
  logic left_on, right_on, rise_smp, fall_smp, frame_end;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [2*SMP_W-1:0] fifo_in_data, fifo_out_data;

  assign left_on = (edge_sel_ff != EDGE_FALL);
  assign right_on = (edge_sel_ff != EDGE_RISE);
  assign rise_smp = rise_dly_ff[SYNC_LAT-1];
  assign fall_smp = fall_dly_ff[SYNC_LAT-1];
  // A frame closes on the falling edge that ends its last clock period
  assign frame_end = fall_smp && (bit_cnt_ff == osr_last(osr_sel_ff));
  assign fifo_in_data = {acc_l_ff,
                         acc_r_ff + SMP_W'(right_on && mic_data_s)};
  // Mic cannot be stalled, so a full queue drops the frame and flags it
  assign ovf_set = frame_end && !fifo_in_ready;

  always_comb begin
    nxt_acc_l = acc_l_ff;
    nxt_acc_r = acc_r_ff;
    nxt_bit_cnt = bit_cnt_ff;
    if (rise_smp && left_on && mic_data_s) begin
      nxt_acc_l = acc_l_ff + 1'b1;
    end
    if (fall_smp && right_on && mic_data_s) begin
      nxt_acc_r = acc_r_ff + 1'b1;
    end
    if (fall_smp) begin
      nxt_bit_cnt = bit_cnt_ff + 8'h01;
    end
    if (frame_end) begin
      nxt_acc_l = '0;
      nxt_acc_r = '0;
      nxt_bit_cnt = 8'h00;
    end
    if (!mic_en) begin
      nxt_acc_l = '0;
      nxt_acc_r = '0;
      nxt_bit_cnt = 8'h00;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      acc_l_ff <= '0;
      acc_r_ff <= '0;
      bit_cnt_ff <= 8'h00;
    end else begin
      acc_l_ff <= nxt_acc_l;
      acc_r_ff <= nxt_acc_r;
      bit_cnt_ff <= nxt_bit_cnt;
    end
  end

  pdmmi_fifo #(
    .W(2 * SMP_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_CORE_CLK),
    .i_rst_b(I_RST_B),
    .i_in_valid(frame_end),
    .o_in_ready(fifo_in_ready),
    .i_in_data(fifo_in_data),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out_data),
    .o_count(fifo_cnt)
  );

  // Output stage keeps sample ports on flops
  logic pcm_valid_ff, nxt_pcm_valid;
  logic [2*SMP_W-1:0] pcm_ff, nxt_pcm;
  logic src_mic_ff, nxt_src_mic;

  assign fifo_pop = fifo_out_valid && (!pcm_valid_ff || I_PCM_READY);

  always_comb begin
    nxt_pcm_valid = pcm_valid_ff;
    nxt_pcm = pcm_ff;
    nxt_src_mic = mic_en;
    if (fifo_pop) begin
      nxt_pcm_valid = 1'b1;
      nxt_pcm = fifo_out_data;
    end else if (I_PCM_READY) begin
      nxt_pcm_valid = 1'b0;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pcm_valid_ff <= 1'b0;
      pcm_ff <= '0;
      src_mic_ff <= 1'b0;
    end else begin
      pcm_valid_ff <= nxt_pcm_valid;
      pcm_ff <= nxt_pcm;
      src_mic_ff <= nxt_src_mic;
    end
  end

  // Port drive
  assign O_PRDATA = prdata_ff;
  assign O_PREADY = pready_ff;
  assign O_PSLVERR = pslverr_ff;
  assign O_MIC_CLK = mclk_ff;
  assign O_MIC_CLK_OE_B = oe_b_ff;
  assign O_PCM_VALID = pcm_valid_ff;
  assign O_PCM_LEFT = pcm_ff[2*SMP_W-1:SMP_W];
  assign O_PCM_RIGHT = pcm_ff[SMP_W-1:0];
  assign O_ADC_SRC_MIC = src_mic_ff;
endmodule // pdmmi_top
`default_nettype wire

// file: verification/pdmmi_checker.sv
// Port assertions for the mic input top.
// Assumes the clock half period stays at its reset value.
`timescale 1ns/1ps
`default_nettype none
module pdmmi_checker
  import pdmmi_pkg::*;
(
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  // Bus
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  // Pins and samples
  input wire logic O_MIC_CLK,
  input wire logic O_MIC_CLK_OE_B,
  input wire logic O_PCM_VALID,
  input wire logic I_PCM_READY,
  input wire logic [SMP_W-1:0] O_PCM_LEFT,
  input wire logic [SMP_W-1:0] O_PCM_RIGHT,
  input wire logic O_ADC_SRC_MIC
);
  localparam int HALF = CLKDIV_RST;
  logic clk_q_ff;
  logic seen_ff;
  logic [7:0] cnt_ff;
  logic nxt_seen;
  logic [7:0] nxt_cnt;
  // Cycles since the last mic clock toggle; the first toggle only arms it
  always_comb begin
    nxt_seen = seen_ff;
    nxt_cnt = cnt_ff + 8'h01;
    if (!O_ADC_SRC_MIC) begin
      nxt_seen = 1'b0;
      nxt_cnt = 8'h00;
    end else if (O_MIC_CLK != clk_q_ff) begin
      nxt_seen = 1'b1;
      nxt_cnt = 8'h00;
    end
  end
  // Registers of the toggle counter
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      clk_q_ff <= 1'b0;
      seen_ff <= 1'b0;
      cnt_ff <= 8'h00;
    end else begin
      clk_q_ff <= O_MIC_CLK;
      seen_ff <= nxt_seen;
      cnt_ff <= nxt_cnt;
    end
  end
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_B);
  a_ready_one_wait: assert property (I_PSEL && !I_PENABLE |=> !O_PREADY ##1 O_PREADY)
    else $error("bus answer not after one wait state");
  a_ready_one_pulse: assert property (O_PREADY |=> !O_PREADY)
    else $error("bus answer longer than one cycle");
  a_err_with_ready: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error flag without answer");
  a_rdata_idle_zero: assert property (!O_PREADY |-> O_PRDATA == 32'h0)
    else $error("read data not zero between answers");
  a_clk_parked_off: assert property (!O_ADC_SRC_MIC [*2] |-> O_MIC_CLK_OE_B && !O_MIC_CLK)
    else $error("mic clock driven while mode off");
  a_clk_driven_on: assert property (O_ADC_SRC_MIC [*2] |-> !O_MIC_CLK_OE_B)
    else $error("mic clock not driven while mode on");
  a_clk_half_period: assert property (seen_ff && O_ADC_SRC_MIC && O_MIC_CLK != clk_q_ff
    |-> cnt_ff == 8'(HALF - 1))
    else $error("mic clock toggled early");
  a_clk_no_stall: assert property (seen_ff && O_ADC_SRC_MIC |-> cnt_ff < 8'(HALF))
    else $error("mic clock toggle late");
  a_pcm_held: assert property (O_PCM_VALID && !I_PCM_READY
    |=> O_PCM_VALID && $stable(O_PCM_LEFT) && $stable(O_PCM_RIGHT))
    else $error("sample changed before taken");
endmodule // pdmmi_checker
bind pdmmi_top pdmmi_checker chk_u (.I_CORE_CLK(I_CORE_CLK), .I_RST_B(I_RST_B),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .O_MIC_CLK(O_MIC_CLK), .O_MIC_CLK_OE_B(O_MIC_CLK_OE_B),
  .O_PCM_VALID(O_PCM_VALID), .I_PCM_READY(I_PCM_READY), .O_PCM_LEFT(O_PCM_LEFT),
  .O_PCM_RIGHT(O_PCM_RIGHT), .O_ADC_SRC_MIC(O_ADC_SRC_MIC));
`default_nettype wire

// file: verification/pdmmi_mic_model.sv
// Behavioural pair of mics sharing one data line.
// Assumes half periods far above the 15 ns data delay.
`timescale 1ns/1ps
`default_nettype none
module pdmmi_mic_model (
  // Clock pin and bit levels
  input wire logic i_clk_pin,
  input wire logic i_oe_b,
  input wire logic i_left_lvl,
  input wire logic i_right_lvl,
  // Shared data line
  output logic o_data
);
  initial o_data = 1'b0;
  // Left mic sets up for the rising edge, after the right bit's hold
  always @(negedge i_clk_pin or negedge i_oe_b) begin
    #15 o_data = i_left_lvl;
  end
  // Right mic sets up for the falling edge
  always @(posedge i_clk_pin) begin
    #15 o_data = i_right_lvl;
  end
  // Released line has no pull, so it wanders rather than keep a level
  always #7 if (i_oe_b) o_data = ~o_data;
endmodule // pdmmi_mic_model
`default_nettype wire

// file: verification/pdmmi_top_tb.sv
// Self-checking bench of the mic input top with the mic pair model.
// Assumes the package, checker and model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module pdmmi_top_tb;
  import pdmmi_pkg::*;
  logic clk = 1'b0;
  logic rst_b, psel, penable, pwrite, ready, mdata, lvl_l, lvl_r, er, pready, perr;
  logic oe_b, mclk, pvalid, src;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] pl, pr;
  logic [15:0] exp_w;
  logic [15:0] exp_q[$];
  logic [7:0] ridx[4] = '{IDX_MODE, IDX_EDGE, IDX_CLKDIV, IDX_STATUS};
  logic [31:0] rrst[4] = '{32'h0, 32'h0, 32'(CLKDIV_RST), 32'h0};
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  pdmmi_top dut_u (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(perr), .O_MIC_CLK(mclk), .O_MIC_CLK_OE_B(oe_b),
    .I_MIC_DATA(mdata), .O_PCM_VALID(pvalid), .I_PCM_READY(ready), .O_PCM_LEFT(pl),
    .O_PCM_RIGHT(pr), .O_ADC_SRC_MIC(src));
  pdmmi_mic_model mic_u (.i_clk_pin(mclk), .i_oe_b(oe_b), .i_left_lvl(lvl_l),
    .i_right_lvl(lvl_r), .o_data(mdata));
  task automatic print_verdict();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard well above the longest run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      print_verdict();
    end
  end
  // Scoreboard: each taken word against the oldest note; an empty queue never matches
  always @(posedge clk) begin
    if (rst_b === 1'b1 && pvalid === 1'b1 && ready === 1'b1) begin
      exp_w = (exp_q.size() != 0) ? exp_q.pop_front() : 16'hffff;
      `CHK({pl, pr}, exp_w)
    end
  end
  function automatic logic [11:0] ra(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction
  // One bus transfer, held until the answer; one idle edge after it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees an answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // One frame at a given rate and edge choice, consumer stalling at random
  task automatic run(input logic [1:0] code, input logic [1:0] edg);
    int osr;
    int n;
    logic l;
    logic r;
    osr = 256 >> code;
    l = 1'($urandom);
    r = 1'($urandom);
    lvl_l <= l;
    lvl_r <= r;
    exp_q.push_back({8'((edg != EDGE_FALL && l) ? osr : 0), 8'((edg != EDGE_RISE && r) ? osr : 0)});
    apb(1'b1, ra(IDX_EDGE), {26'h0, edg, 4'h0});
    apb(1'b1, ra(IDX_MODE), {26'h0, code, 4'h0});
    apb(1'b0, ra(IDX_STATUS), 32'h0);
    `CHK({rd[ST_EN_BIT], src}, 2'b11)
    for (n = 0; n < 4000 && exp_q.size() != 0; n++) begin
      ready <= 1'($urandom);
      @(posedge clk);
    end
    ready <= 1'b1;
    apb(1'b1, ra(IDX_MODE), 32'h0);
    @(posedge clk);
    `CHK({src, oe_b, exp_q.size()}, {2'b01, 32'h0})
  endtask
  initial begin
    {rst_b, psel, penable, pwrite, ready, lvl_l, lvl_r} = 7'h08;
    paddr = 12'h000;
    pwdata = 32'h0;
    void'($urandom(32'h3a01a9f7));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ra(ridx[i]), 32'h0);
      `CHK(rd, rrst[i])
    end
    apb(1'b0, 12'hffc, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    apb(1'b1, ra(IDX_CLKDIV), 32'h0);
    apb(1'b0, ra(IDX_CLKDIV), 32'h0);
    `CHK(rd, 32'(CLKDIV_RST))
    apb(1'b1, ra(IDX_CLKDIV), 32'h0000010d);
    apb(1'b0, ra(IDX_CLKDIV), 32'h0);
    `CHK(rd, 32'h0000000d)
    apb(1'b1, ra(IDX_CLKDIV), 32'(CLKDIV_RST));
    apb(1'b1, ra(IDX_EDGE), 32'hff);
    apb(1'b0, ra(IDX_EDGE), 32'h0);
    `CHK(rd, 32'h30)
    for (int c = 1; c < 4; c++) run(2'(c), EDGE_BOTH);
    // Edge-select runs: rising only and falling only count zero on the unused channel; code 3 counts both
    for (int e = 1; e < 4; e++) run(OSR_32, 2'(e));
    // Overflow: consumer stalls over eleven 32x frames; nine words survive
    ready <= 1'b0;
    lvl_l <= 1'b1;
    lvl_r <= 1'b0;
    apb(1'b1, ra(IDX_EDGE), 32'h0);
    apb(1'b1, ra(IDX_MODE), {26'h0, OSR_32, 4'h0});
    repeat (11 * 2 * 32 * 12) @(posedge clk);
    apb(1'b1, ra(IDX_MODE), 32'h0);
    apb(1'b0, ra(IDX_STATUS), 32'h0);
    `CHK(rd, 32'h82)
    repeat (9) exp_q.push_back(16'h2000);
    ready <= 1'b1;
    for (int n = 0; n < 40 && exp_q.size() != 0; n++) @(posedge clk);
    apb(1'b1, ra(IDX_STATUS), 32'h2);
    apb(1'b0, ra(IDX_STATUS), 32'h0);
    `CHK({rd, exp_q.size()}, 64'h0)
    print_verdict();
  end
endmodule // pdmmi_top_tb
`default_nettype wire
